// *** common/rgn_pkg.sv ***
// shared constants and carriers for the regenerator control bank
package rgn_pkg;
   // register offsets
   localparam logic [7:0] RGN_OFS_ACT = 8'h01;
   localparam logic [7:0] RGN_OFS_CHIP = 8'h02;
   localparam logic [7:0] RGN_OFS_INCTL = 8'h03;
   // reset values
   localparam logic [7:0] RGN_CHIP_RST = 8'h0C;
   localparam logic [7:0] RGN_INCTL_RST = 8'h12;
   // chip-control fields
   localparam int RGN_CC_SRST = 4;
   localparam int RGN_CC_PWRDN = 5;
   // input-control fields
   localparam int RGN_IC_CLK_HIZ = 2;
   localparam int RGN_IC_DAT_HIZ = 3;
   localparam int RGN_IC_ACT_MODE = 4;
   localparam int RGN_IC_HYST_EN = 5;
   localparam int RGN_IC_HYST_MAG = 6;
   localparam int RGN_IC_RECAL = 7;
   // activity register field
   localparam int RGN_ACT_FLAG = 2;
   // timing
   localparam int RGN_CLK_PERIOD_NS = 100;
   localparam int RGN_SRST_TIME_NS = 1000;
   localparam int RGN_SRST_CYC =
      (RGN_SRST_TIME_NS + RGN_CLK_PERIOD_NS - 1) / RGN_CLK_PERIOD_NS;
   localparam int RGN_AUTO_CAL_TIME_NS = 1000000;
   localparam int RGN_AUTO_CAL_CYC =
      (RGN_AUTO_CAL_TIME_NS + RGN_CLK_PERIOD_NS - 1) / RGN_CLK_PERIOD_NS;
   // serial byte framing
   localparam logic [3:0] RGN_BIT_LAST = 4'h7;
   localparam logic [3:0] RGN_BIT_CNT = 4'h8;
   // one register write from the serial port
   typedef struct packed {
      logic stb;
      logic [7:0] addr;
      logic [7:0] data;
   } rgn_wr_t;
   // controls towards the analog front end
   typedef struct packed {
      logic link_out_en;
      logic link_in_open;
      logic clk_in_hiz;
      logic data_in_hiz;
      logic act_mode_cm;
      logic hyst_en;
      logic hyst_20mv;
      logic term_cal;
      logic chip_reset;
   } rgn_ana_t;
   // serial slave states
   typedef enum logic [2:0] {
      RGN_I2C_IDLE = 3'b000,
      RGN_I2C_ADDR = 3'b001,
      RGN_I2C_AACK = 3'b010,
      RGN_I2C_WDATA = 3'b011,
      RGN_I2C_RDATA = 3'b100,
      RGN_I2C_MACK = 3'b101
   } rgn_i2c_st_t;
endpackage : rgn_pkg

// *** sim/regen_chip_and_input_control_bench.sv ***
// self-checking bench for the regenerator control bank
`timescale 1ns/1ps
module regen_chip_and_input_control_bench;
   import rgn_pkg::*;
   localparam int CAL_SIM = 20;
   logic clk_sys_in, resetn_in, power_down_pin_in, ext_reset_pin_in;
   logic scl, sda_drv, sda_w, sda_out, sda_oe_out, ac_in, cm_in;
   logic power_down_out, activity_out;
   rgn_ana_t ana_ctrl_out;
   int n_errors = 0;
   int num_checks = 0;
   int n_rst = 0;
   // open-drain wire with pull-up
   assign sda_w = sda_drv & (sda_oe_out ? 1'b1 : sda_out);
   rgn_ctrl_bank #(.CAL_CYCLES(CAL_SIM)) dut_u (
      .clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
      .power_down_pin_in(power_down_pin_in), .ext_reset_pin_in(ext_reset_pin_in),
      .scl_in(scl), .sda_in(sda_w), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
      .link_clock_input_ac_in(ac_in), .link_clock_input_cm_in(cm_in),
      .ana_ctrl_out(ana_ctrl_out), .power_down_out(power_down_out),
      .activity_out(activity_out));
   rgn_host_model mst_u (.clk_in(clk_sys_in), .sda_wire_in(sda_w), .scl_out(scl),
      .sda_drv_out(sda_drv));
   // 10 MHz clock
   initial begin
      clk_sys_in = 1'b0;
      forever #50 clk_sys_in = ~clk_sys_in;
   end
   // count cycles with the full-reset output up
   always @(posedge clk_sys_in) begin
      if (ana_ctrl_out.chip_reset === 1'b1) n_rst++;
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys_in);
      #10;
   endtask : cyc
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("Error t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic wchk(input logic [7:0] a, input logic [7:0] d);
      logic nak;
      mst_u.wr(a, d, nak);
      chk(nak, 8'h00);
   endtask : wchk
   task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      mst_u.rd(a, d);
      chk(d, exp);
   endtask : rchk
   task automatic t_reset();
      cyc(4);
      chk(ana_ctrl_out.term_cal, 8'h01);
      chk(ana_ctrl_out.link_out_en, 8'h01);
      chk(ana_ctrl_out.act_mode_cm, 8'h01);
      cyc(40);
      chk(ana_ctrl_out.term_cal, 8'h00);
      rchk(RGN_OFS_CHIP, 8'h0C);
      rchk(RGN_OFS_INCTL, 8'h12);
      $display("test reset done");
   endtask : t_reset
   task automatic t_inctl();
      logic [7:0] vals [4] = '{8'h0F, 8'h73, 8'h13, 8'h63};
      foreach (vals[i]) begin
         wchk(RGN_OFS_INCTL, vals[i]);
         rchk(RGN_OFS_INCTL, vals[i]);
         chk(ana_ctrl_out.clk_in_hiz, vals[i][2]);
         chk(ana_ctrl_out.data_in_hiz, vals[i][3]);
         chk(ana_ctrl_out.act_mode_cm, vals[i][4]);
         chk(ana_ctrl_out.hyst_en, vals[i][5]);
         chk(ana_ctrl_out.hyst_20mv, vals[i][6]);
      end
      $display("test input control done");
   endtask : t_inctl
   task automatic t_act();
      for (int m = 0; m < 2; m++) begin
         wchk(RGN_OFS_INCTL, 8'h63 | 8'(m << 4));
         for (int k = 0; k < 4; k++) begin
            ac_in = k[0];
            cm_in = k[1];
            cyc(10);
            chk(activity_out, m ? k[1] : k[0]);
         end
      end
      wchk(RGN_OFS_INCTL, 8'h63);
      ac_in = 1'b1;
      cm_in = 1'b0;
      rchk(RGN_OFS_ACT, 8'h04);
      $display("test activity done");
   endtask : t_act
   task automatic t_pwr();
      wchk(RGN_OFS_CHIP, 8'h2C);
      chk(power_down_out, 8'h01);
      chk(ana_ctrl_out.link_out_en, 8'h00);
      chk(ana_ctrl_out.link_in_open, 8'h01);
      chk(activity_out, 8'h00);
      rchk(RGN_OFS_CHIP, 8'h2C);
      wchk(RGN_OFS_CHIP, 8'h0C);
      chk(power_down_out, 8'h00);
      power_down_pin_in = 1'b1;
      cyc(6);
      chk(power_down_out, 8'h01);
      chk(ana_ctrl_out.link_out_en, 8'h00);
      // a write while powered down must still land
      wchk(RGN_OFS_INCTL, 8'h73);
      rchk(RGN_OFS_INCTL, 8'h73);
      power_down_pin_in = 1'b0;
      cyc(6);
      chk(power_down_out, 8'h00);
      wchk(RGN_OFS_INCTL, 8'hE3);
      chk(ana_ctrl_out.term_cal, 8'h01);
      cyc(10000);
      wchk(RGN_OFS_INCTL, 8'h63);
      chk(ana_ctrl_out.term_cal, 8'h00);
      $display("test power-down done");
   endtask : t_pwr
   task automatic t_srst();
      int n0;
      n0 = n_rst;
      wchk(RGN_OFS_CHIP, 8'h1C);
      cyc(20);
      chk(8'(n_rst - n0), 8'(RGN_SRST_CYC));
      rchk(RGN_OFS_CHIP, 8'h0C);
      rchk(RGN_OFS_INCTL, 8'h12);
      $display("test full reset done");
   endtask : t_srst
   task automatic t_pin();
      wchk(RGN_OFS_INCTL, 8'h63);
      ext_reset_pin_in = 1'b1;
      cyc(5);
      chk(ana_ctrl_out.chip_reset, 8'h01);
      ext_reset_pin_in = 1'b0;
      cyc(5);
      chk(ana_ctrl_out.chip_reset, 8'h00);
      rchk(RGN_OFS_INCTL, 8'h12);
      rchk(8'h05, 8'h00);
      $display("test reset pin done");
   endtask : t_pin
   task automatic summarize();
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : summarize
   // main sequence, reset held 20 cycles
   initial begin
      resetn_in = 1'b0;
      power_down_pin_in = 1'b0;
      ext_reset_pin_in = 1'b0;
      ac_in = 1'b0;
      cm_in = 1'b0;
      cyc(20);
      resetn_in = 1'b1;
      t_reset();
      t_inctl();
      t_act();
      t_pwr();
      t_srst();
      t_pin();
      summarize();
   end
   // watchdog well past the expected run of about 25000 cycles
   initial begin
      repeat (60000) @(posedge clk_sys_in);
      n_errors++;
      summarize();
   end
endmodule : regen_chip_and_input_control_bench

// *** sim/rgn_host_model.sv ***
// host controller model driving the two-wire management port
`timescale 1ns/1ps
module rgn_host_model #(
   parameter logic [6:0] DEV_ADDR = 7'h50
) (
   // clock and bus wire
   input wire logic clk_in,
   input wire logic sda_wire_in,
   // driven lines, sda is open drain so 1 means released
   output logic scl_out,
   output logic sda_drv_out
);
   // idle bus: clock high, data released to the pull-up
   initial begin
      scl_out = 1'b1;
      sda_drv_out = 1'b1;
   end
   // wait n clocks then step just past the edge
   task automatic hw(input int n);
      repeat (n) @(posedge clk_in);
      #10;
   endtask : hw
   // one bit, sampled mid-high; each of the four phases lasts 4 clocks
   task automatic bit_x(input logic b, output logic r);
      sda_drv_out = b;
      hw(4);
      scl_out = 1'b1;
      hw(4);
      r = sda_wire_in;
      hw(4);
      scl_out = 1'b0;
      hw(4);
   endtask : bit_x
   // byte msb first, then the ninth bit (released, so ack in or nack out)
   task automatic byte_x(input logic [7:0] d, output logic [7:0] r, output logic ak);
      for (int i = 7; i >= 0; i--) begin
         bit_x(d[i], r[i]);
      end
      bit_x(1'b1, ak);
   endtask : byte_x
   // start or repeated start
   task automatic start();
      sda_drv_out = 1'b1;
      hw(4);
      scl_out = 1'b1;
      hw(8);
      sda_drv_out = 1'b0;
      hw(8);
      scl_out = 1'b0;
      hw(4);
   endtask : start
   // stop, leaves the bus idle
   task automatic stop();
      sda_drv_out = 1'b0;
      hw(4);
      scl_out = 1'b1;
      hw(8);
      sda_drv_out = 1'b1;
      hw(8);
   endtask : stop
   // register write; nak is 0 only when all three bytes were acked
   task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic nak);
      logic [7:0] r;
      logic k0, k1, k2;
      start();
      byte_x({DEV_ADDR, 1'b0}, r, k0);
      byte_x(a, r, k1);
      byte_x(d, r, k2);
      stop();
      nak = k0 | k1 | k2;
   endtask : wr
   // register read with pointer write, repeated start, final nack
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      logic [7:0] r;
      logic k;
      start();
      byte_x({DEV_ADDR, 1'b0}, r, k);
      byte_x(a, r, k);
      start();
      byte_x({DEV_ADDR, 1'b1}, r, k);
      byte_x(8'hFF, d, k);
      stop();
   endtask : rd
endmodule : rgn_host_model

// *** verilog/rgn_ctrl_bank.sv ***
// chip-control and input-control register bank of the link regenerator
`timescale 1ns/1ps
module rgn_ctrl_bank
   import rgn_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR = 7'h50,
   parameter int CAL_CYCLES = RGN_AUTO_CAL_CYC,
   parameter int CAL_W = 16
) (
   // clock and reset
   input wire logic clk_sys_in,
   input wire logic resetn_in,
   // device pins
   input wire logic power_down_pin_in,
   input wire logic ext_reset_pin_in,
   // serial management port
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_out,
   // analog status
   input wire logic link_clock_input_ac_in,
   input wire logic link_clock_input_cm_in,
   // analog controls and status
   output rgn_ana_t ana_ctrl_out,
   output logic power_down_out,
   output logic activity_out
);
   localparam logic [CAL_W-1:0] CAL_LOAD = CAL_W'(CAL_CYCLES);
   localparam logic [3:0] SRST_LOAD = 4'(RGN_SRST_CYC);
   localparam int A_SRST = RGN_SRST_CYC;

   // whole state of the bank
   typedef struct packed {
      logic pwr_m, pwr_s;
      logic xr_m, xr_s;
      logic ac_m, ac_s;
      logic cm_m, cm_s;
      logic [7:0] chip;
      logic [7:0] inctl;
      logic [3:0] srst_cnt;
      logic [CAL_W-1:0] cal_cnt;
      logic act;
      logic pwr_dn;
      rgn_ana_t ana;
   } rgn_bank_st_t;

   // calibration counter preset so power-on starts a calibration
   localparam rgn_bank_st_t ST_RST = '{chip: RGN_CHIP_RST,
      inctl: RGN_INCTL_RST, cal_cnt: CAL_LOAD, default: '0};

   logic [1:0] rst_q;
   logic rst_n;
   rgn_bank_st_t s;
   rgn_bank_st_t next_s;
   rgn_wr_t wr;
   logic [7:0] rd_addr;
   logic [7:0] rd_data;
   logic pwr_now;

   // reset release through two flops, assertion is immediate
   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rst_q <= 2'b00;
      end else begin
         rst_q <= {rst_q[0], 1'b1};
      end
   end
   assign rst_n = rst_q[1];

   // serial slave lives on the system clock only
   rgn_i2c_slave #(
      .DEV_ADDR(DEV_ADDR)
   ) u_i2c (
      .clk_in(clk_sys_in),
      .rst_n_in(rst_n),
      .scl_in(scl_in),
      .sda_in(sda_in),
      .sda_out(sda_out),
      .sda_oe_out(sda_oe_out),
      .wr_out(wr),
      .rd_addr_out(rd_addr),
      .rd_data_in(rd_data)
   );

   // either source forces power-down
   assign pwr_now = s.chip[RGN_CC_PWRDN] | s.pwr_s;

   // readback mux, unmapped offsets read zero
   always_comb begin
      rd_data = '0;
      unique case (rd_addr)
         RGN_OFS_ACT: rd_data[RGN_ACT_FLAG] = s.act;
         RGN_OFS_CHIP: rd_data = s.chip;
         RGN_OFS_INCTL: rd_data = s.inctl;
         default: rd_data = '0;
      endcase
   end

   // next-state logic
   always_comb begin
      next_s = s;
      // pin synchronisers
      next_s.pwr_m = power_down_pin_in;
      next_s.pwr_s = s.pwr_m;
      next_s.xr_m = ext_reset_pin_in;
      next_s.xr_s = s.xr_m;
      next_s.ac_m = link_clock_input_ac_in;
      next_s.ac_s = s.ac_m;
      next_s.cm_m = link_clock_input_cm_in;
      next_s.cm_s = s.cm_m;
      // calibration timer runs down on its own
      if (s.cal_cnt != '0) begin
         next_s.cal_cnt = s.cal_cnt - CAL_W'(1);
      end
      if (s.srst_cnt != '0) begin
         // writes are dropped while a full reset runs
         next_s.srst_cnt = s.srst_cnt - 4'h1;
         if (s.srst_cnt == 4'h1) begin
            next_s.chip = RGN_CHIP_RST;
            next_s.inctl = RGN_INCTL_RST;
            next_s.cal_cnt = CAL_LOAD;
         end
      end else if (s.xr_s) begin
         // pin reset holds defaults for as long as it is high
         next_s.chip = RGN_CHIP_RST;
         next_s.inctl = RGN_INCTL_RST;
         next_s.cal_cnt = CAL_LOAD;
      end else if (wr.stb) begin
         // accepted even in power-down
         unique case (wr.addr)
            RGN_OFS_CHIP: begin
               next_s.chip = wr.data;
               if (wr.data[RGN_CC_SRST]) begin
                  next_s.srst_cnt = SRST_LOAD;
               end
            end
            RGN_OFS_INCTL: next_s.inctl = wr.data;
            default: begin
            end
         endcase
      end
      // activity: method chosen by mode bit, blank in power-down
      if (pwr_now) begin
         next_s.act = 1'b0;
      end else if (s.inctl[RGN_IC_ACT_MODE]) begin
         next_s.act = s.cm_s;
      end else begin
         next_s.act = s.ac_s;
      end
      next_s.pwr_dn = pwr_now;
      // analog control outputs
      next_s.ana.link_out_en = ~pwr_now;
      next_s.ana.link_in_open = pwr_now;
      next_s.ana.clk_in_hiz = s.inctl[RGN_IC_CLK_HIZ];
      next_s.ana.data_in_hiz = s.inctl[RGN_IC_DAT_HIZ];
      next_s.ana.act_mode_cm = s.inctl[RGN_IC_ACT_MODE];
      // hysteresis only reaches the clock receivers
      next_s.ana.hyst_en = s.inctl[RGN_IC_HYST_EN];
      next_s.ana.hyst_20mv = s.inctl[RGN_IC_HYST_MAG];
      // software holds the recal bit for its own minimum time
      next_s.ana.term_cal = (s.cal_cnt != '0) | s.inctl[RGN_IC_RECAL];
      next_s.ana.chip_reset = s.chip[RGN_CC_SRST] | s.xr_s;
   end

   // single state register
   always_ff @(posedge clk_sys_in or negedge rst_n) begin
      if (!rst_n) begin
         s <= ST_RST;
      end else begin
         s <= next_s;
      end
   end

   assign ana_ctrl_out = s.ana;
   assign power_down_out = s.pwr_dn;
   assign activity_out = s.act;

   // checks
   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (!rst_n);

   // full reset request taken from the port
   sequence sr_start;
      wr.stb && wr.addr == RGN_OFS_CHIP && wr.data[RGN_CC_SRST]
         && s.srst_cnt == 4'h0 && !s.xr_s;
   endsequence
   sequence sr_busy;
      s.chip[RGN_CC_SRST] && s.srst_cnt == SRST_LOAD;
   endsequence
   sequence sr_done;
      s.chip == RGN_CHIP_RST && s.inctl == RGN_INCTL_RST
         && s.srst_cnt == 4'h0;
   endsequence

   a_srst_self_clear: assert property (sr_start |=> sr_busy ##A_SRST sr_done)
      else $error("full reset did not self-clear on time");
   a_srst_out_high: assert property (s.chip[RGN_CC_SRST] |=> ana_ctrl_out.chip_reset)
      else $error("chip reset output low during full reset");
   a_pwr_outputs: assert property (pwr_now |=> !ana_ctrl_out.link_out_en
      && ana_ctrl_out.link_in_open && power_down_out)
      else $error("power-down did not disable link");
   a_pwr_normal: assert property (!pwr_now |=> ana_ctrl_out.link_out_en
      && !ana_ctrl_out.link_in_open)
      else $error("link disabled without power-down");
   a_pwr_pin_or: assert property (power_down_pin_in [*3] |=> power_down_out)
      else $error("power-down pin ignored");
   a_pwr_bit_or: assert property (s.chip[RGN_CC_PWRDN] && !s.pwr_s |=> power_down_out)
      else $error("power-down bit ignored");
   a_mgmt_alive: assert property (pwr_now && wr.stb && wr.addr == RGN_OFS_INCTL
      && s.srst_cnt == 4'h0 && !s.xr_s |=> s.inctl == $past(wr.data))
      else $error("write lost in power-down");
   a_auto_cal: assert property ($rose(rst_n) |-> ##[1:3] ana_ctrl_out.term_cal)
      else $error("no calibration after power-on");
   a_cal_idle: assert property (s.cal_cnt == '0 && !s.inctl[RGN_IC_RECAL]
      |=> !ana_ctrl_out.term_cal)
      else $error("calibration active without cause");
   a_hiz_map: assert property (
      ##1 {ana_ctrl_out.data_in_hiz, ana_ctrl_out.clk_in_hiz}
      == $past(s.inctl[RGN_IC_DAT_HIZ:RGN_IC_CLK_HIZ]))
      else $error("tri-state controls mismatch");
   a_act_ac: assert property (!pwr_now && !s.inctl[RGN_IC_ACT_MODE] && s.ac_s
      |=> activity_out)
      else $error("ac activity not reported");
   a_act_cm: assert property (!pwr_now && s.inctl[RGN_IC_ACT_MODE] && !s.cm_s
      |=> !activity_out)
      else $error("common-mode activity wrong");
   a_hyst_map: assert property (
      ##1 ana_ctrl_out.hyst_en == $past(s.inctl[RGN_IC_HYST_EN])
      && ana_ctrl_out.hyst_20mv == $past(s.inctl[RGN_IC_HYST_MAG]))
      else $error("hysteresis controls mismatch");
   a_reset_vals: assert property ($rose(rst_n) |-> s.chip == RGN_CHIP_RST
      && s.inctl == RGN_INCTL_RST)
      else $error("wrong register reset values");
   a_pin_reset: assert property (s.xr_s && s.srst_cnt == 4'h0
      |=> s.chip == RGN_CHIP_RST && s.inctl == RGN_INCTL_RST)
      else $error("pin reset did not restore defaults");
endmodule : rgn_ctrl_bank

// *** verilog/rgn_i2c_slave.sv ***
// two-wire management port slave with register pointer
`timescale 1ns/1ps
module rgn_i2c_slave
   import rgn_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR = 7'h50
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // serial pins
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_out,
   // register side
   output rgn_wr_t wr_out,
   output logic [7:0] rd_addr_out,
   input wire logic [7:0] rd_data_in
);
   typedef struct packed {
      logic scl_m, scl_s, scl_d;
      logic sda_m, sda_s, sda_d;
      rgn_i2c_st_t st;
      logic [3:0] cnt;
      logic [7:0] sh;
      logic [7:0] ptr;
      logic got_ptr;
      logic rw;
      logic drv_low;
      logic oe;
      rgn_wr_t wr;
   } rgn_i2c_reg_t;

   localparam rgn_i2c_reg_t ST_RST = '{scl_m: 1'b1, scl_s: 1'b1, scl_d: 1'b1,
      sda_m: 1'b1, sda_s: 1'b1, sda_d: 1'b1, st: RGN_I2C_IDLE, oe: 1'b1,
      default: '0};

   rgn_i2c_reg_t s;
   rgn_i2c_reg_t next_s;
   logic start, stop, rise, fall;

   // bus conditions from synchronised copies only
   assign start = s.scl_s & s.scl_d & s.sda_d & ~s.sda_s;
   assign stop = s.scl_s & s.scl_d & ~s.sda_d & s.sda_s;
   assign rise = s.scl_s & ~s.scl_d;
   assign fall = ~s.scl_s & s.scl_d;

   // protocol engine
   always_comb begin
      next_s = s;
      next_s.scl_m = scl_in;
      next_s.scl_s = s.scl_m;
      next_s.scl_d = s.scl_s;
      next_s.sda_m = sda_in;
      next_s.sda_s = s.sda_m;
      next_s.sda_d = s.sda_s;
      next_s.wr.stb = 1'b0;
      if (start) begin
         next_s.st = RGN_I2C_ADDR;
         next_s.cnt = '0;
         next_s.got_ptr = 1'b0;
         next_s.drv_low = 1'b0;
      end else if (stop) begin
         next_s.st = RGN_I2C_IDLE;
         next_s.drv_low = 1'b0;
      end else begin
         unique case (s.st)
            RGN_I2C_IDLE: begin
            end
            RGN_I2C_ADDR, RGN_I2C_WDATA: begin
               if (rise) begin
                  next_s.sh = {s.sh[6:0], s.sda_s};
                  next_s.cnt = s.cnt + 4'h1;
               end else if (fall && s.cnt == RGN_BIT_CNT) begin
                  next_s.cnt = '0;
                  next_s.drv_low = 1'b1;
                  next_s.st = RGN_I2C_AACK;
                  if (s.st == RGN_I2C_ADDR) begin
                     next_s.rw = s.sh[0];
                     if (s.sh[7:1] != DEV_ADDR) begin
                        next_s.drv_low = 1'b0;
                        next_s.st = RGN_I2C_IDLE;
                     end
                  end else if (!s.got_ptr) begin
                     next_s.ptr = s.sh;
                     next_s.got_ptr = 1'b1;
                  end else begin
                     next_s.wr = '{stb: 1'b1, addr: s.ptr, data: s.sh};
                     next_s.ptr = s.ptr + 8'h01;
                  end
               end
            end
            RGN_I2C_AACK, RGN_I2C_MACK: begin
               // a nack from the master ends the read burst
               if (s.st == RGN_I2C_MACK && rise && s.sda_s) begin
                  next_s.st = RGN_I2C_IDLE;
               end else if (fall) begin
                  if (s.rw) begin
                     next_s.sh = rd_data_in;
                     next_s.drv_low = ~rd_data_in[7];
                     next_s.st = RGN_I2C_RDATA;
                  end else begin
                     next_s.drv_low = 1'b0;
                     next_s.st = RGN_I2C_WDATA;
                  end
               end
            end
            RGN_I2C_RDATA: begin
               if (fall) begin
                  if (s.cnt == RGN_BIT_LAST) begin
                     next_s.cnt = '0;
                     next_s.drv_low = 1'b0;
                     next_s.ptr = s.ptr + 8'h01;
                     next_s.st = RGN_I2C_MACK;
                  end else begin
                     next_s.cnt = s.cnt + 4'h1;
                     next_s.sh = {s.sh[6:0], 1'b0};
                     next_s.drv_low = ~s.sh[6];
                  end
               end
            end
            default: next_s.st = RGN_I2C_IDLE;
         endcase
      end
      // enable kept in its own flop so the pin has no gate after it
      next_s.oe = ~next_s.drv_low;
   end

   // state register
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         s <= ST_RST;
      end else begin
         s <= next_s;
      end
   end

   // open drain: data always low, enable low while pulling
   assign sda_out = 1'b0;
   assign sda_oe_out = s.oe;
   assign wr_out = s.wr;
   assign rd_addr_out = s.ptr;
endmodule : rgn_i2c_slave
